// ==== pus_host.sv ====
// Far-side model: host on the control port and the boot loader.
// Assumes the sequencer clock; drives only at its falling edge.
`timescale 1ns/100ps
module pus_host (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic init_busy_i,
    input wire logic boot_req_i,
    input wire logic wr_ok_i,
    input wire logic rd_ok_i,
    input wire logic [7:0] nbytes_i,
    output pus_pkg::pus_ctl_req_t ctl_req_o,
    output logic boot_byte_o,
    output logic boot_done_o
);
    logic sent_q = 1'b0; // Loader already ran since reset

    // Idle outputs from time zero
    initial begin
        ctl_req_o = '0;
        boot_byte_o = 1'b0;
        boot_done_o = 1'b0;
    end

    // ------------------------------------------------------------
    // Host access; early set breaks the wait on purpose
    // ------------------------------------------------------------
    task automatic access(input logic wr, input logic [15:0] addr,
                          input logic early, output logic ok);
        int n;
        n = 0;
        while (init_busy_i === 1'b1 && !early && n < 1000) begin
            @(negedge mclk_i);
            n++;
        end
        @(negedge mclk_i);
        ctl_req_o = '{wr: wr, rd: !wr, addr: addr};
        @(negedge mclk_i);
        // Grant stands one cycle only, so take it before releasing
        ok = wr ? wr_ok_i : rd_ok_i;
        // Released address shows garbage, not the last value
        ctl_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~addr};
    endtask : access

    // ------------------------------------------------------------
    // Loader: a short load, then finish early
    // ------------------------------------------------------------
    always begin
        @(negedge mclk_i);
        if (rst_i) begin
            sent_q = 1'b0;
        end else if (boot_req_i === 1'b1 && !sent_q) begin
            // Spaced bytes, far fewer than a full image
            for (int i = 0; i < nbytes_i; i++) begin
                boot_byte_o = 1'b1;
                @(negedge mclk_i);
                boot_byte_o = 1'b0;
                @(negedge mclk_i);
            end
            boot_done_o = 1'b1;
            @(negedge mclk_i);
            boot_done_o = 1'b0;
            sent_q = 1'b1;
        end
    end
endmodule : pus_host

// ==== pus_pkg.sv ====
// Package of the power-up init sequencer: constants, strap decode table,
// mode and state encodings, and the state and request carriers.
// Assumes one clock (the crystal input clock) and no software registers.
package pus_pkg;

    // ------------------------------------------------------------
    // Timing of the initialization interval
    // ------------------------------------------------------------
    localparam int INIT_EXP = 15;              // Interval exponent
    localparam int INIT_PERIODS = 1 << INIT_EXP; // Divided periods per init
    localparam int PER_W = 17;                 // Period counter width
    localparam int PRE_W = 4;                  // Prescale counter width

    // ------------------------------------------------------------
    // Divider strap decode, indexed by {bit2, bit1, bit0}
    // ------------------------------------------------------------
    localparam logic [2:0] STRAP_DIV4 = 3'h2;  // Low, high, low
    localparam logic [3:0] DIV_TABLE [8] = '{
        4'h1, 4'h2, 4'h4, 4'h3, 4'h6, 4'h8, 4'h5, 4'h1};

    // ------------------------------------------------------------
    // Accepted master clock ratios, in normal-rate units
    // ------------------------------------------------------------
    localparam logic [11:0] RATIO_64 = 12'h040;
    localparam logic [11:0] RATIO_128 = 12'h080;
    localparam logic [11:0] RATIO_256 = 12'h100;
    localparam logic [11:0] RATIO_384 = 12'h180;
    localparam logic [11:0] RATIO_512 = 12'h200;

    // Processing rate modes
    typedef enum logic [1:0] {
        RATE_NORMAL = 2'h0,
        RATE_DUAL = 2'h1,
        RATE_QUAD = 2'h2
    } pus_rate_t;

    // ------------------------------------------------------------
    // Control port and boot constants
    // ------------------------------------------------------------
    localparam logic [15:0] RO_FIRST = 16'hF000; // Read-only window start
    localparam logic [15:0] RO_LAST = 16'hFFFF;  // Read-only window end
    localparam logic [13:0] BOOT_MAX_BYTES = 14'h2400; // Full 9 kB load
    localparam int SUB_CNT = 4;                  // Gated subsystems

    // Sequencer states
    typedef enum logic [2:0] {
        ST_CAPTURE = 3'h0,
        ST_INIT = 3'h1,
        ST_BOOT = 3'h2,
        ST_READY = 3'h3
    } pus_st_t;

    // Control port access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
    } pus_ctl_req_t;

    // Whole module state
    typedef struct packed {
        pus_st_t st;
        logic [PRE_W-1:0] pre;
        logic [PER_W-1:0] per;
        logic [3:0] div;
        logic spi_sel;
        logic selfboot;
        logic [13:0] boot_cnt;
        logic [SUB_CNT-1:0] clk_en;
        logic init_busy;
        logic boot_req;
        logic wr_ok;
        logic rd_ok;
        logic ratio_ok;
    } pus_state_t;

endpackage : pus_pkg

// ==== pus_seq.sv ====
// Power-up init sequencer: strap capture, timed init interval, clock
// gating of subsystems, optional self-boot and control port gating.
// Assumes rst_i is the inverted device reset pin and mclk_i is the
// crystal input clock; straps and requests are synchronous to mclk_i.
`timescale 1ns/100ps

// Operation
// [RULE1] Capture divider straps at reset release
// [RULE2] Block master clock during initialization
// [RULE3] Init lasts 2^15 periods of divided clock
// [RULE4] Strap pattern low-high-low selects divider four
// [RULE5] Host writes nothing before init completes
// [RULE6] Accept 64-512 ratios, scaled by rate mode
// [RULE7] Read all; write all but read-only
// [RULE8] Control port selectable as SPI or I2C
// [RULE9] Self-boot from external EEPROM at startup
// [RULE10] Per-subsystem master clock blocking
// [RULE11] Partial boot load up to 9 kB allowed
// [RULE12] New reset aborts and restarts initialization
module pus_seq #(
    parameter int INIT_PERIODS = pus_pkg::INIT_PERIODS
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic pll_div_sel_bit0_i,
    input wire logic pll_div_sel_bit1_i,
    input wire logic pll_div_sel_bit2_i,
    input wire logic spi_mode_i,
    input wire logic selfboot_i,
    input wire pus_pkg::pus_rate_t rate_mode_i,
    input wire logic [9:0] mclk_ratio_i,
    input wire logic [pus_pkg::SUB_CNT-1:0] sub_use_i,
    input wire pus_pkg::pus_ctl_req_t ctl_req_i,
    input wire logic boot_byte_i,
    input wire logic boot_done_i,
    output logic [3:0] pll_div_o,
    output logic init_busy_o,
    output logic [pus_pkg::SUB_CNT-1:0] sub_clk_en_o,
    output logic ctl_spi_sel_o,
    output logic boot_req_o,
    output logic ctl_wr_ok_o,
    output logic ctl_rd_ok_o,
    output logic ratio_ok_o
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Period counter must be able to reach the end count
    if (INIT_PERIODS < 1 || INIT_PERIODS >= (1 << pus_pkg::PER_W)) begin
        $error("INIT_PERIODS out of range");
    end

    localparam logic [pus_pkg::PER_W-1:0] PER_END =
        pus_pkg::PER_W'(INIT_PERIODS - 1);

    // ------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------
    // Address falls in the read-only window
    function automatic logic is_ro(input logic [15:0] addr);
        is_ro = (addr >= pus_pkg::RO_FIRST) && (addr <= pus_pkg::RO_LAST);
    endfunction : is_ro

    // Ratio scaled back to normal-rate units is one of the five
    function automatic logic ratio_ok(input logic [9:0] r,
                                      input pus_pkg::pus_rate_t m);
        logic [11:0] n;
        n = {2'h0, r};
        case (m)
            pus_pkg::RATE_DUAL: n = {1'h0, r, 1'h0};
            pus_pkg::RATE_QUAD: n = {r, 2'h0};
            default: n = {2'h0, r};
        endcase
        ratio_ok = (n == pus_pkg::RATIO_64) || (n == pus_pkg::RATIO_128) ||
                   (n == pus_pkg::RATIO_256) || (n == pus_pkg::RATIO_384) ||
                   (n == pus_pkg::RATIO_512);
    endfunction : ratio_ok

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pus_pkg::pus_state_t s_q; // Registered state
    pus_pkg::pus_state_t s_d; // Next state
    logic [2:0] strap;        // Strap pins as one code
    logic pre_wrap;           // Prescaler ends a divided period

    assign strap = {pll_div_sel_bit2_i, pll_div_sel_bit1_i,
                    pll_div_sel_bit0_i};
    assign pre_wrap = (s_q.pre == pus_pkg::PRE_W'(s_q.div - 4'h1));

    // Next-state logic for the whole sequencer
    always_comb begin
        s_d = s_q;
        s_d.wr_ok = 1'b0;
        s_d.rd_ok = 1'b0;
        // Ratio check is steady; registered so the output is a flop
        s_d.ratio_ok = ratio_ok(mclk_ratio_i, rate_mode_i); // [RULE6]
        case (s_q.st)
            // First edge after release: latch straps, start counting
            pus_pkg::ST_CAPTURE: begin
                s_d.div = pus_pkg::DIV_TABLE[strap]; // [RULE1] [RULE4]
                s_d.spi_sel = spi_mode_i; // [RULE8]
                s_d.selfboot = selfboot_i;
                s_d.pre = '0;
                s_d.per = '0; // [RULE12]
                s_d.init_busy = 1'b1;
                s_d.clk_en = '0; // [RULE2]
                s_d.st = pus_pkg::ST_INIT;
            end
            // Count divided-clock periods with clocks held off
            pus_pkg::ST_INIT: begin
                s_d.clk_en = '0; // [RULE2]
                if (pre_wrap) begin
                    s_d.pre = '0;
                    if (s_q.per == PER_END) begin // [RULE3]
                        s_d.init_busy = 1'b0;
                        if (s_q.selfboot) begin
                            s_d.boot_req = 1'b1; // [RULE9]
                            s_d.boot_cnt = '0;
                            s_d.st = pus_pkg::ST_BOOT;
                        end else begin
                            s_d.st = pus_pkg::ST_READY;
                        end
                    end else begin
                        s_d.per = s_q.per + 1'b1;
                    end
                end else begin
                    s_d.pre = s_q.pre + 1'b1;
                end
            end
            // Loader streams bytes; a short load may end early
            pus_pkg::ST_BOOT: begin
                if (boot_byte_i) begin
                    s_d.boot_cnt = s_q.boot_cnt + 1'b1;
                end
                // Ends on done or at the full image size
                if (boot_done_i || (boot_byte_i && s_q.boot_cnt ==
                    pus_pkg::BOOT_MAX_BYTES - 14'h1)) begin // [RULE11]
                    s_d.boot_req = 1'b0;
                    s_d.st = pus_pkg::ST_READY;
                end
            end
            // Normal running: clocks follow the per-subsystem enables
            pus_pkg::ST_READY: begin
                s_d.clk_en = sub_use_i; // [RULE10]
                s_d.rd_ok = ctl_req_i.rd; // [RULE7]
                // Writes only after init and never to read-only space
                s_d.wr_ok = ctl_req_i.wr && !is_ro(ctl_req_i.addr); // [RULE7]
            end
            default: begin
                s_d.st = pus_pkg::ST_CAPTURE;
            end
        endcase
    end

    // State register; reset returns to capture, aborting any interval
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '{st: pus_pkg::ST_CAPTURE, div: 4'h1,
                     init_busy: 1'b1, default: '0}; // [RULE12]
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from the state flops
    // ------------------------------------------------------------
    assign pll_div_o = s_q.div;
    assign init_busy_o = s_q.init_busy;
    assign sub_clk_en_o = s_q.clk_en;
    assign ctl_spi_sel_o = s_q.spi_sel;
    assign boot_req_o = s_q.boot_req;
    assign ctl_wr_ok_o = s_q.wr_ok;
    assign ctl_rd_ok_o = s_q.rd_ok;
    assign ratio_ok_o = s_q.ratio_ok;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    // Cycles spent in the interval, for the length check
    int init_len;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            init_len <= 0;
        end else if (s_q.st == pus_pkg::ST_INIT) begin
            init_len <= init_len + 1;
        end else begin
            init_len <= 0;
        end
    end

    strap_capture_a: assert property ( // [RULE1]
        s_q.st == pus_pkg::ST_CAPTURE |=>
            pll_div_o == pus_pkg::DIV_TABLE[$past(strap)])
        else $error("divider not taken from straps");
    div_four_map_a: assert property ( // [RULE4]
        s_q.st == pus_pkg::ST_CAPTURE && strap == pus_pkg::STRAP_DIV4
            |=> pll_div_o == 4'h4)
        else $error("low-high-low straps not divider four");
    clocks_blocked_a: assert property ( // [RULE2]
        init_busy_o |-> sub_clk_en_o == '0)
        else $error("subsystem clock running during init");
    init_length_a: assert property ( // [RULE3]
        s_q.st == pus_pkg::ST_INIT && s_d.st != pus_pkg::ST_INIT |->
            init_len + 1 == INIT_PERIODS * int'(s_q.div))
        else $error("init interval length wrong");
    no_write_init_a: assert property ( // [RULE5]
        init_busy_o |-> !ctl_wr_ok_o)
        else $error("write granted during init");
    ratio_check_a: assert property ( // [RULE6]
        rate_mode_i == pus_pkg::RATE_DUAL && mclk_ratio_i == 10'h0C0
            |=> ratio_ok_o)
        else $error("dual-rate ratio 192 refused");
    ro_refused_a: assert property ( // [RULE7]
        ctl_req_i.wr && is_ro(ctl_req_i.addr) |=> !ctl_wr_ok_o)
        else $error("write to read-only address granted");
    port_select_a: assert property ( // [RULE8]
        s_q.st == pus_pkg::ST_CAPTURE |=> ctl_spi_sel_o == $past(spi_mode_i))
        else $error("port mode not latched");
    boot_entry_a: assert property ( // [RULE9]
        $rose(boot_req_o) |->
            $past(init_busy_o) && !init_busy_o && s_q.selfboot)
        else $error("boot request outside init end");
    boot_cap_a: assert property ( // [RULE11]
        boot_req_o && boot_byte_i &&
            s_q.boot_cnt == pus_pkg::BOOT_MAX_BYTES - 14'h1 |=> !boot_req_o)
        else $error("boot ran past full image");
    sub_gate_a: assert property ( // [RULE10]
        s_q.st == pus_pkg::ST_READY |=> sub_clk_en_o == $past(sub_use_i))
        else $error("subsystem enable not followed");
    restart_zero_a: assert property ( // [RULE12]
        s_q.st == pus_pkg::ST_CAPTURE |=> s_q.per == '0 && init_busy_o)
        else $error("init not restarted from zero");

    init_done_c: cover property (
        init_busy_o ##1 !init_busy_o && !boot_req_o);
    selfboot_c: cover property (boot_req_o ##[1:50] !boot_req_o);
    write_ok_c: cover property (ctl_wr_ok_o);
    early_reset_c: cover property (
        s_q.st == pus_pkg::ST_INIT && s_q.per == '0 && s_q.pre != '0);

endmodule : pus_seq

// ==== tb_top.sv ====
// Self-checking bench for the power-up init sequencer.
// Assumes the host model file; all stimulus at the falling edge.
`timescale 1ns/100ps
module tb_top;
    localparam int P = 8; // Short interval keeps the run brief
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] strap = 3'h0; // {bit2, bit1, bit0}
    logic spi = 1'b0;
    logic boot = 1'b0;
    pus_pkg::pus_rate_t rate = pus_pkg::RATE_NORMAL;
    logic [9:0] ratio = 10'h040;
    logic [3:0] sub_use = 4'hA;
    logic [7:0] nbytes = 8'h05; // Partial boot load size
    pus_pkg::pus_ctl_req_t req;
    logic bbyte, bdone, busy, breq, wok, rok, spi_sel, r_ok;
    logic [3:0] div, clk_en;
    int miscompares = 0;
    int cmp_count = 0;

    initial begin
        forever #20 mclk = ~mclk;
    end

    pus_seq #(.INIT_PERIODS(P)) i_dut (.mclk_i(mclk), .rst_i(rst),
        .pll_div_sel_bit0_i(strap[0]), .pll_div_sel_bit1_i(strap[1]),
        .pll_div_sel_bit2_i(strap[2]), .spi_mode_i(spi),
        .selfboot_i(boot), .rate_mode_i(rate), .mclk_ratio_i(ratio),
        .sub_use_i(sub_use), .ctl_req_i(req), .boot_byte_i(bbyte),
        .boot_done_i(bdone), .pll_div_o(div), .init_busy_o(busy),
        .sub_clk_en_o(clk_en), .ctl_spi_sel_o(spi_sel),
        .boot_req_o(breq), .ctl_wr_ok_o(wok), .ctl_rd_ok_o(rok),
        .ratio_ok_o(r_ok));

    pus_host i_host (.mclk_i(mclk), .rst_i(rst), .init_busy_i(busy),
        .boot_req_i(breq), .wr_ok_i(wok), .rd_ok_i(rok),
        .nbytes_i(nbytes), .ctl_req_o(req), .boot_byte_o(bbyte),
        .boot_done_o(bdone));

    // ------------------------------------------------------------
    // Compare and closing report
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    // Bounded wait for init and boot to end; a hang fails the run
    task automatic wait_idle();
        int n;
        n = 0;
        while ((busy === 1'b1 || breq === 1'b1) && n < 200) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 200) begin
            miscompares++;
            end_sim();
        end
    endtask : wait_idle

    // Straps only change while reset is held
    task automatic restart(input logic [2:0] s, input logic sp,
                           input logic bt);
        @(negedge mclk);
        rst = 1'b1;
        strap = s;
        spi = sp;
        boot = bt;
        repeat (4) @(negedge mclk);
        chk(div, 4'h1);
        chk(busy, 1'b1);
        rst = 1'b0;
    endtask : restart

    // Full interval measured in edges from release
    task automatic init_run(input logic [2:0] s, input logic sp,
                            input logic bt);
        int n;
        logic [3:0] d;
        d = pus_pkg::DIV_TABLE[s];
        restart(s, sp, bt);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
            if (n == 2) chk(div, d);
            chk(clk_en, 4'h0);
        end while (busy === 1'b1 && n < 100);
        chk(16'(n), 16'(1 + P * d));
        if (n >= 100) end_sim();
        chk(spi_sel, sp);
        chk(breq, bt);
    endtask : init_run

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_straps();
        for (int s = 0; s < 8; s++) begin
            init_run(3'(s), 1'(s), 1'b0);
        end
        init_run(pus_pkg::STRAP_DIV4, 1'b1, 1'b0);
        chk(div, 4'h4);
    endtask : t_straps

    // Reset mid-interval must restart the count from zero
    task automatic t_abort();
        restart(3'h5, 1'b0, 1'b0);
        repeat (10) @(negedge mclk);
        init_run(3'h5, 1'b0, 1'b0);
    endtask : t_abort

    task automatic t_ctl();
        logic ok;
        restart(3'h2, 1'b1, 1'b0);
        i_host.access(1'b1, 16'h0010, 1'b1, ok);
        chk(ok, 1'b0);
        wait_idle();
        i_host.access(1'b1, 16'h0010, 1'b0, ok);
        chk(ok, 1'b1);
        i_host.access(1'b1, pus_pkg::RO_FIRST, 1'b0, ok);
        chk(ok, 1'b0);
        i_host.access(1'b0, pus_pkg::RO_LAST, 1'b0, ok);
        chk(ok, 1'b1);
        i_host.access(1'b1, pus_pkg::RO_FIRST - 16'h1, 1'b0, ok);
        chk(ok, 1'b1);
    endtask : t_ctl

    // Multiples of 64; 192, 320 and 448 are never legal
    task automatic t_ratio();
        for (int m = 0; m < 3; m++) begin
            for (int b = 64; b <= 512; b += 64) begin
                @(negedge mclk);
                rate = pus_pkg::pus_rate_t'(2'(m));
                ratio = 10'(b >> m);
                repeat (2) @(negedge mclk);
                chk(r_ok, b != 192 && b != 320 && b != 448);
            end
        end
    endtask : t_ratio

    // Short self-boot; clocks stay blocked until it ends
    task automatic t_boot();
        int n;
        init_run(3'h2, 1'b0, 1'b1);
        n = 0;
        while (breq === 1'b1 && n < 200) begin
            chk(clk_en, 4'h0);
            @(negedge mclk);
            n++;
        end
        if (n >= 200) begin
            miscompares++;
            end_sim();
        end
        chk(n >= 11 && n <= 12, 1'b1);
        repeat (2) @(negedge mclk);
        chk(clk_en, 4'hA);
        sub_use = 4'h5;
        repeat (2) @(negedge mclk);
        chk(clk_en, 4'h5);
    endtask : t_boot

    initial begin
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        t_straps();
        t_abort();
        t_ctl();
        t_ratio();
        t_boot();
        end_sim();
    end
endmodule : tb_top
